/* core/lsr_pkg.sv */
// constants and types for the live status register block
package lsr_pkg;
  localparam logic [7:0] LSR_ADDR = 8'h2F;
  localparam logic [15:0] LSR_RESET = 16'h0000;
  localparam int LSR_RDY_BIT = 14;
  localparam int LSR_BUSY_BIT = 13;
  localparam int LSR_SRC_LO = 10;
  localparam int LSR_R1V8_BIT = 9;
  localparam int LSR_DVCC_BIT = 8;
  localparam int LSR_AVDD_BIT = 7;
  localparam int LSR_R5V_BIT = 6;
  localparam int LSR_CP_BIT = 5;
  localparam int LSR_TEMP_BIT = 4;
  localparam int CLK_MHZ = 25;
  localparam int RDY_PULSE_US = 24;
  localparam int RDY_PULSE_CYC = RDY_PULSE_US * CLK_MHZ;
  localparam logic [9:0] RDY_PULSE_CNT = 10'(RDY_PULSE_CYC);
  typedef enum logic [1:0] {
    LSR_PIN_IDLE = 2'b00,
    LSR_PIN_HOLD = 2'b01,
    LSR_PIN_WAIT = 2'b10
  } lsr_pin_t;
endpackage : lsr_pkg

/* core/lsr_ready_pin.sv */
// ready pin driver for single and continuous conversion modes
`timescale 1ns/10ps
module lsr_ready_pin import lsr_pkg::*; (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic continuous_in,
  input wire logic done_in,
  input wire logic flag_in,
  output logic ready_n_out
);
  lsr_pin_t st_q, st_d;
  logic [9:0] cnt_q, cnt_d;
  logic rdy_n_q, rdy_n_d;

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    rdy_n_d = rdy_n_q;
    case (st_q)
      LSR_PIN_IDLE: begin
        if (done_in) begin
          rdy_n_d = 1'b0;
          cnt_d = RDY_PULSE_CNT - 10'h001;
          st_d = continuous_in ? LSR_PIN_HOLD : LSR_PIN_WAIT;
        end else begin
          rdy_n_d = 1'b1;
        end
      end
      LSR_PIN_HOLD: begin
        // fixed low time, flag ignored
        if (cnt_q == 10'h000) begin
          rdy_n_d = 1'b1;
          st_d = LSR_PIN_IDLE;
        end else begin
          cnt_d = cnt_q - 10'h001;
        end
      end
      LSR_PIN_WAIT: begin
        // follows flag, releases once cleared
        if (!flag_in && !done_in) begin
          rdy_n_d = 1'b1;
          st_d = LSR_PIN_IDLE;
        end
      end
      default: begin
        st_d = LSR_PIN_IDLE;
        rdy_n_d = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_q <= LSR_PIN_IDLE;
      cnt_q <= 10'h000;
      rdy_n_q <= 1'b1;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      rdy_n_q <= rdy_n_d;
    end
  end

  assign ready_n_out = rdy_n_q;

  logic [9:0] low_cnt_q;
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      low_cnt_q <= 10'h000;
    end else if (!rdy_n_q && st_q == LSR_PIN_HOLD) begin
      low_cnt_q <= low_cnt_q + 10'h001;
    end else begin
      low_cnt_q <= 10'h000;
    end
  end

  pulse_len_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    low_cnt_q <= RDY_PULSE_CNT) else $error("ready low too long");
  pin_follow_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (st_q == LSR_PIN_WAIT && flag_in) |=> !rdy_n_q) else $error("pin left flag");
endmodule : lsr_ready_pin

/* core/lsr_top.sv */
// live status register with data-ready flag and ready pin
`timescale 1ns/10ps
module lsr_top import lsr_pkg::*; (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  input wire logic [7:0] addr_in,
  input wire logic [15:0] wdata_in,
  output logic [15:0] rdata_out,
  input wire logic continuous_in,
  input wire logic conv_done_in,
  input wire logic adc_busy_in,
  input wire logic [2:0] converting_source_field_in,
  input wire logic reg_1v8_fault_in,
  input wire logic digital_supply_fault_in,
  input wire logic analog_supply_fault_in,
  input wire logic reg_5v_fault_in,
  input wire logic charge_pump_fault_in,
  input wire logic overheat_fault_in,
  input wire logic [3:0] channel_io_fault_in,
  output logic data_ready_out,
  output logic adc_ready_n_out
);
  logic flag_q, flag_d;
  logic [15:0] live_q, live_d;
  logic [15:0] rdata_q, rdata_d;
  logic clr;

  assign clr = wr_en_in && addr_in == LSR_ADDR && wdata_in[LSR_RDY_BIT];

  always_comb begin
    // set wins over a same-cycle clear
    flag_d = conv_done_in ? 1'b1 : (clr ? 1'b0 : flag_q);
    live_d = LSR_RESET; // bit 15 stays zero, writes only clear the flag in bit 14
    live_d[LSR_RDY_BIT] = flag_d;
    live_d[LSR_BUSY_BIT] = adc_busy_in;
    live_d[LSR_SRC_LO +: 3] = converting_source_field_in;
    live_d[LSR_R1V8_BIT] = reg_1v8_fault_in;
    live_d[LSR_DVCC_BIT] = digital_supply_fault_in;
    live_d[LSR_AVDD_BIT] = analog_supply_fault_in;
    live_d[LSR_R5V_BIT] = reg_5v_fault_in;
    live_d[LSR_CP_BIT] = charge_pump_fault_in;
    live_d[LSR_TEMP_BIT] = overheat_fault_in;
    live_d[3:0] = channel_io_fault_in;
    rdata_d = (rd_en_in && addr_in == LSR_ADDR) ? live_q : 16'h0000;
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      flag_q <= 1'b0;
      live_q <= LSR_RESET;
      rdata_q <= 16'h0000;
    end else begin
      flag_q <= flag_d;
      live_q <= live_d;
      rdata_q <= rdata_d;
    end
  end

  assign rdata_out = rdata_q;
  assign data_ready_out = flag_q;

  lsr_ready_pin u_pin (
    .clk_in(clk_in),
    .arst_n_in(arst_n_in),
    .continuous_in(continuous_in),
    .done_in(conv_done_in),
    .flag_in(flag_q),
    .ready_n_out(adc_ready_n_out)
  );

  flag_set_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    conv_done_in |=> flag_q) else $error("flag not set");
  flag_hold_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (flag_q && !clr) |=> flag_q) else $error("flag dropped");
  top_zero_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    !live_q[15] && !rdata_q[15]) else $error("bit 15 set");
  busy_live_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    live_q[LSR_BUSY_BIT] == $past(adc_busy_in)) else $error("busy lag");
  src_live_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    live_q[12:10] == $past(converting_source_field_in)) else $error("source lag");
  supply_live_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    live_q[9:6] == {$past(reg_1v8_fault_in), $past(digital_supply_fault_in),
    $past(analog_supply_fault_in), $past(reg_5v_fault_in)}) else $error("supply lag");
  misc_live_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    live_q[5:0] == {$past(charge_pump_fault_in), $past(overheat_fault_in),
    $past(channel_io_fault_in)}) else $error("fault lag");
  read_data_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (rd_en_in && addr_in == LSR_ADDR) |=> rdata_q == $past(live_q)) else $error("bad read");
endmodule : lsr_top

/* dv/lsr_host.sv */
// host-side register access model for the live status register
`timescale 1ns/10ps
module lsr_host import lsr_pkg::*; (
  input wire logic clk_in,
  output logic wr_en_out,
  output logic rd_en_out,
  output logic [7:0] addr_out,
  output logic [15:0] wdata_out
);
  initial begin
    wr_en_out = 1'b0;
    rd_en_out = 1'b0;
    addr_out = 8'h00;
    wdata_out = 16'h0000;
  end
  // one strobe cycle, launched and released on falling edges
  task automatic access(input logic wr, input logic [7:0] a, input logic [15:0] d);
    @(negedge clk_in);
    wr_en_out = wr;
    rd_en_out = !wr;
    addr_out = a;
    wdata_out = d;
    @(negedge clk_in);
    wr_en_out = 1'b0;
    rd_en_out = 1'b0;
    wdata_out = ~d;
  endtask : access
endmodule : lsr_host

/* dv/live_status_register_tb.sv */
// self-checking bench for the live status register
`timescale 1ns/10ps
module live_status_register_tb import lsr_pkg::*;;
  logic clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic cont = 1'b0;
  logic done = 1'b0;
  logic [13:0] live = 14'h0000;
  logic wr, rd_s, rdy, rdy_n;
  logic [7:0] addr;
  logic [15:0] wdata, rdata;
  int error_cnt = 0;
  int samples_checked = 0;
  int cyc = 0;
  int n;
  // live inputs map one to one onto bits 13:0 of the image
  logic [15:0] rows [19] = '{16'h0000, 16'h2000, 16'h0400, 16'h0800, 16'h0C00, 16'h1000,
    16'h1400, 16'h1800, 16'h1C00, 16'h0200, 16'h0100, 16'h0080, 16'h0040, 16'h0020,
    16'h0010, 16'h0008, 16'h0004, 16'h0002, 16'h0001};
  always #20 clk_in = ~clk_in;
  lsr_host i_lsr_host (.clk_in(clk_in), .wr_en_out(wr), .rd_en_out(rd_s), .addr_out(addr),
    .wdata_out(wdata));
  lsr_top i_lsr_top (.clk_in(clk_in), .arst_n_in(arst_n_in), .wr_en_in(wr), .rd_en_in(rd_s),
    .addr_in(addr), .wdata_in(wdata), .rdata_out(rdata), .continuous_in(cont),
    .conv_done_in(done), .adc_busy_in(live[13]), .converting_source_field_in(live[12:10]),
    .reg_1v8_fault_in(live[9]), .digital_supply_fault_in(live[8]),
    .analog_supply_fault_in(live[7]), .reg_5v_fault_in(live[6]),
    .charge_pump_fault_in(live[5]), .overheat_fault_in(live[4]),
    .channel_io_fault_in(live[3:0]), .data_ready_out(rdy), .adc_ready_n_out(rdy_n));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    i_lsr_host.access(1'b0, a, 16'h0000);
    check(rdata, exp);
  endtask : rd
  task automatic end_sim();
    $display("errors %0d, comparisons %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_sim
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 4000) begin
      error_cnt++;
      end_sim();
    end
  end
  initial begin
    repeat (20) @(negedge clk_in);
    check({rdata[13:0], rdy, rdy_n}, 16'h0001);
    arst_n_in = 1'b1;
    foreach (rows[i]) begin
      @(negedge clk_in);
      live = rows[i][13:0];
      rd(LSR_ADDR, rows[i]);
    end
    live = 14'h3FFF;
    rd(8'h10, 16'h0000);
    i_lsr_host.access(1'b1, LSR_ADDR, 16'hFFFF);
    rd(LSR_ADDR, 16'h3FFF);
    live = 14'h0000;
    @(negedge clk_in);
    done = 1'b1;
    @(negedge clk_in);
    done = 1'b0;
    check({14'h0000, rdy, rdy_n}, 16'h0002);
    repeat (700) @(negedge clk_in);
    i_lsr_host.access(1'b1, LSR_ADDR, 16'hBFFF);
    check({14'h0000, rdy, rdy_n}, 16'h0002);
    rd(LSR_ADDR, 16'h4000);
    i_lsr_host.access(1'b1, LSR_ADDR, 16'h4000);
    @(negedge clk_in);
    check({14'h0000, rdy, rdy_n}, 16'h0001);
    cont = 1'b1;
    done = 1'b1;
    @(negedge clk_in);
    done = 1'b0;
    n = 0;
    while (rdy_n === 1'b0 && n < 1000) begin
      @(negedge clk_in);
      n++;
    end
    check(16'(n), 16'(RDY_PULSE_CYC));
    check({15'h0000, rdy}, 16'h0001);
    cont = 1'b0;
    fork
      i_lsr_host.access(1'b1, LSR_ADDR, 16'h4000);
      begin
        @(negedge clk_in);
        done = 1'b1;
        @(negedge clk_in);
        done = 1'b0;
      end
    join
    check({15'h0000, rdy}, 16'h0001);
    arst_n_in = 1'b0;
    repeat (3) @(negedge clk_in);
    check({rdata[13:0], rdy, rdy_n}, 16'h0001);
    arst_n_in = 1'b1;
    @(negedge clk_in);
    rd(LSR_ADDR, 16'h0000);
    end_sim();
  end
endmodule : live_status_register_tb
